// *** include/cms_defs.vh ***
// Overview of operation
// R1 - key pages erase automatically when key upload begins, before any key is accepted
// R2 - erasure clears exactly the 32 key pages and nothing else
// R3 - data outputs inhibited in key entry, self-test, erasure and error states
// R4 - operative only after self-test pass (status 101) and verified key selection
// R5 - no cryptographic operation or data before operative state
// R6 - failed self-test enters error state, refusing operations, outputs inhibited
// R7 - self-test is one known-answer test compared with expected result
// R8 - full self-test reruns after every reset; reset requests it on demand
// R9 - self-test starts unprompted; approved mode entered automatically on pass
// R10 - incomplete commands or requests are discarded without side effects
// R11 - cipher invocations per key limited to two to the fortieth minus one
// R12 - nonce counter read by request 112, loaded by ground command 96
// R13 - firmware version returned on a dedicated request
// R14 - keys never appear on outputs; referenced only by identifier
// R15 - up to 32 keys, identifiers 1 to 32
// R16 - key and checksum bytes majority-voted over three copies, checksum recomputed
// R17 - three-bit readable status code: pass value, distinct error value
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH
`define CMS_ST_SELFTEST 3'h0
`define CMS_ST_ERASE 3'h1
`define CMS_ST_KEYENTRY 3'h2
`define CMS_ST_READY 3'h3
`define CMS_ST_KEYREAD 3'h4
`define CMS_ST_OPER 3'h5
`define CMS_ST_ERROR 3'h6
`define CMS_STAT_TEST 3'h1
`define CMS_STAT_RUN 3'h2
`define CMS_STAT_PASS 3'h5
`define CMS_STAT_ERROR 3'h7
`define CMS_SUB_NONCE_SET 8'h60
`define CMS_SUB_NONCE_GET 8'h70
`define CMS_SUB_FW_GET 8'h71
`define CMS_SUB_STAT_GET 8'h72
`define CMS_SUB_KEY_SEL 8'h73
`define CMS_LEN_NONCE_SET 3'h7
`define CMS_LEN_REQ 3'h1
`define CMS_LEN_KEY_SEL 3'h2
`define CMS_LEN_NONE 3'h0
`define CMS_LEN_MAX 3'h7
`define CMS_LAST_PAGE 5'h1f
`define CMS_KEY_ID_MIN 6'h01
`define CMS_KEY_ID_MAX 6'h20
`define CMS_CHK_BYTE 5'h10
`define CMS_INV_LIMIT 40'hffffffffff
`define CMS_CRC_POLY 8'h07
`define CMS_CRC_INIT 8'h00
`endif

// *** rtl/cms_state_control.v ***
`timescale 1ns/1ns
`include "cms_defs.vh"
module cms_state_control #(
  parameter [127:0] KAT_EXPECTED = 128'h0123456789abcdeffedcba9876543210,
  parameter [23:0] FW_VERSION = 24'h010000
) (
  input wire clk,
  input wire resetn,
  input wire keyHarness,
  output reg katStart,
  input wire katResultValid,
  input wire [127:0] katResult,
  output reg eraseReq,
  output reg [4:0] erasePage,
  input wire eraseAck,
  output reg keyLoadReady,
  output reg rdReq,
  output reg [4:0] rdPage,
  output reg [4:0] rdByte,
  input wire rdValid,
  input wire [7:0] rdCopyA,
  input wire [7:0] rdCopyB,
  input wire [7:0] rdCopyC,
  input wire gndValid,
  input wire [7:0] gndData,
  input wire gndEnd,
  input wire hkValid,
  input wire [7:0] hkData,
  input wire hkEnd,
  input wire cipherReq,
  output reg cipherGo,
  output reg [47:0] cipherNonce,
  output reg [5:0] keyIdActive,
  output reg limitReached,
  output reg keyCheckFail,
  output reg dataOutEnable,
  output reg [2:0] statusCode,
  output reg replyValid,
  output reg [7:0] replySubtype,
  output reg [47:0] replyData
);
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] crc_reg;
  reg [39:0] invCount [0:31];
  wire [1:0] portValid;
  wire [1:0] portEnd;
  wire [15:0] portData;
  wire [1:0] cmdDone;
  wire [15:0] cmdSub;
  wire [95:0] cmdPay;
  wire [7:0] voted;
  wire [4:0] keyIdx;
  wire curAtLimit;
  wire gndNonce;
  wire hkNonce;
  wire hkFw;
  wire hkStat;
  wire hkSel;
  wire selOk;
  wire replyAllowed;

  function [7:0] crcByte;
    input [7:0] crcIn;
    input [7:0] dat;
    integer i;
    reg [7:0] c;
    begin
      c = crcIn ^ dat;
      for (i = 0; i < 8; i = i + 1) begin
        c = c[7] ? ((c << 1) ^ `CMS_CRC_POLY) : (c << 1);
      end
      crcByte = c;
    end
  endfunction

  function [2:0] expLen;
    input [7:0] sub;
    begin
      case (sub)
        `CMS_SUB_NONCE_SET: expLen = `CMS_LEN_NONCE_SET;
        `CMS_SUB_NONCE_GET: expLen = `CMS_LEN_REQ;
        `CMS_SUB_FW_GET: expLen = `CMS_LEN_REQ;
        `CMS_SUB_STAT_GET: expLen = `CMS_LEN_REQ;
        `CMS_SUB_KEY_SEL: expLen = `CMS_LEN_KEY_SEL;
        default: expLen = `CMS_LEN_NONE;
      endcase
    end
  endfunction

  // port 0 is the ground link, port 1 the housekeeping link
  assign portValid = {hkValid, gndValid};
  assign portEnd = {hkEnd, gndEnd};
  assign portData = {hkData, gndData};

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : gParser
      reg [2:0] cnt_reg;
      reg [7:0] sub_reg;
      reg [47:0] pay_reg;
      reg done_reg;
      reg [7:0] subOut_reg;
      reg [47:0] payOut_reg;
      wire [7:0] b;
      wire [7:0] curSub;
      wire [2:0] cntInc;
      assign b = portData[8*p+7:8*p];
      assign curSub = (cnt_reg == 3'h0) ? b : sub_reg;
      assign cntInc = cnt_reg + 3'h1;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt_reg <= 3'h0;
          sub_reg <= 8'h00;
          pay_reg <= 48'h0;
          done_reg <= 1'b0;
          subOut_reg <= 8'h00;
          payOut_reg <= 48'h0;
        end else begin
          done_reg <= 1'b0;
          if (portValid[p]) begin
            if (cnt_reg == 3'h0) begin
              sub_reg <= b;
            end
            if (cnt_reg != 3'h0) begin
              pay_reg <= {pay_reg[39:0], b};
            end
            if (portEnd[p]) begin
              cnt_reg <= 3'h0;
              // only a frame of exactly the expected length is released; others vanish
              if (expLen(curSub) != `CMS_LEN_NONE && cntInc == expLen(curSub)) begin // R10
                done_reg <= 1'b1;
                subOut_reg <= curSub;
                payOut_reg <= (cnt_reg == 3'h0) ? pay_reg : {pay_reg[39:0], b};
              end
            end else if (cnt_reg != `CMS_LEN_MAX) begin
              cnt_reg <= cntInc;
            end
          end
        end
      end
      assign cmdDone[p] = done_reg;
      assign cmdSub[8*p+7:8*p] = subOut_reg;
      assign cmdPay[48*p+47:48*p] = payOut_reg;
    end
  endgenerate

  assign gndNonce = cmdDone[0] && cmdSub[7:0] == `CMS_SUB_NONCE_SET;
  assign hkNonce = cmdDone[1] && cmdSub[15:8] == `CMS_SUB_NONCE_GET;
  assign hkFw = cmdDone[1] && cmdSub[15:8] == `CMS_SUB_FW_GET;
  assign hkStat = cmdDone[1] && cmdSub[15:8] == `CMS_SUB_STAT_GET;
  assign hkSel = cmdDone[1] && cmdSub[15:8] == `CMS_SUB_KEY_SEL;
  assign selOk = cmdPay[53:48] >= `CMS_KEY_ID_MIN && cmdPay[55:54] == 2'h0 && cmdPay[53:48] <= `CMS_KEY_ID_MAX; // R15
  assign replyAllowed = state_reg == `CMS_ST_READY || state_reg == `CMS_ST_OPER; // R3
  assign voted = (rdCopyA & rdCopyB) | (rdCopyA & rdCopyC) | (rdCopyB & rdCopyC); // R16
  assign keyIdx = keyIdActive[4:0] - 5'h1;
  assign curAtLimit = invCount[keyIdx] == `CMS_INV_LIMIT;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `CMS_ST_SELFTEST: begin
        if (katResultValid) begin
          if (katResult != KAT_EXPECTED) begin // R7
            state_next = `CMS_ST_ERROR; // R6
          end else if (keyHarness) begin
            state_next = `CMS_ST_ERASE; // R1
          end else begin
            state_next = `CMS_ST_READY; // R9
          end
        end
      end
      `CMS_ST_ERASE: begin
        if (eraseAck && erasePage == `CMS_LAST_PAGE) begin
          state_next = `CMS_ST_KEYENTRY; // R1
        end
      end
      `CMS_ST_KEYENTRY: state_next = `CMS_ST_KEYENTRY;
      `CMS_ST_READY, `CMS_ST_OPER: begin
        if (hkSel && selOk) begin
          state_next = `CMS_ST_KEYREAD;
        end
      end
      `CMS_ST_KEYREAD: begin
        if (rdValid && rdByte == `CMS_CHK_BYTE) begin
          state_next = (crc_reg == voted) ? `CMS_ST_OPER : `CMS_ST_READY; // R4
        end
      end
      `CMS_ST_ERROR: state_next = `CMS_ST_ERROR; // R6
      default: state_next = `CMS_ST_ERROR;
    endcase
  end

  // every reset lands here, so the known-answer test always reruns
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= `CMS_ST_SELFTEST; // R8
      katStart <= 1'b0;
      statusCode <= `CMS_STAT_TEST;
    end else begin
      state_reg <= state_next;
      katStart <= 1'b0;
      if (state_reg == `CMS_ST_SELFTEST && katStart == 1'b0 && statusCode == `CMS_STAT_TEST) begin
        katStart <= 1'b1; // R9
      end
      if (state_reg == `CMS_ST_SELFTEST && katStart) begin
        statusCode <= `CMS_STAT_RUN;
      end
      if (state_reg == `CMS_ST_SELFTEST && katResultValid) begin
        statusCode <= (state_next == `CMS_ST_ERROR) ? `CMS_STAT_ERROR : `CMS_STAT_PASS; // R17
      end
    end
  end

  // erase walks pages 0..31 only, one acknowledge per page
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eraseReq <= 1'b0;
      erasePage <= 5'h00;
      keyLoadReady <= 1'b0;
    end else begin
      eraseReq <= state_next == `CMS_ST_ERASE; // R1
      keyLoadReady <= state_next == `CMS_ST_KEYENTRY; // R1
      if (state_reg == `CMS_ST_ERASE && eraseAck && erasePage != `CMS_LAST_PAGE) begin
        erasePage <= erasePage + 5'h1; // R2
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdReq <= 1'b0;
      rdPage <= 5'h00;
      rdByte <= 5'h00;
      crc_reg <= `CMS_CRC_INIT;
      keyIdActive <= 6'h00;
      keyCheckFail <= 1'b0;
    end else begin
      rdReq <= 1'b0;
      if (state_reg != `CMS_ST_KEYREAD && state_next == `CMS_ST_KEYREAD) begin
        // the identifier is latched now, the key itself never leaves this block
        keyIdActive <= cmdPay[53:48]; // R14
        rdPage <= cmdPay[52:48] - 5'h1;
        rdByte <= 5'h00;
        rdReq <= 1'b1;
        crc_reg <= `CMS_CRC_INIT;
      end else if (state_reg == `CMS_ST_KEYREAD && rdValid) begin
        if (rdByte == `CMS_CHK_BYTE) begin
          keyCheckFail <= crc_reg != voted; // R16
        end else begin
          crc_reg <= crcByte(crc_reg, voted); // R16
          rdByte <= rdByte + 5'h1;
          rdReq <= 1'b1;
        end
      end
    end
  end

  generate
    for (p = 0; p < 32; p = p + 1) begin : gInv
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          invCount[p] <= 40'h0;
        end else if (state_reg == `CMS_ST_ERASE) begin
          invCount[p] <= 40'h0;
        end else if (cipherReq && state_reg == `CMS_ST_OPER && keyIdx == p && !curAtLimit) begin
          invCount[p] <= invCount[p] + 40'h1; // R11
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cipherGo <= 1'b0;
      cipherNonce <= 48'h0;
      limitReached <= 1'b0;
      dataOutEnable <= 1'b0;
    end else begin
      dataOutEnable <= state_next == `CMS_ST_OPER; // R3
      cipherGo <= cipherReq && state_reg == `CMS_ST_OPER && !curAtLimit; // R5
      limitReached <= state_reg == `CMS_ST_OPER && curAtLimit; // R11
      if (gndNonce && replyAllowed) begin
        cipherNonce <= cmdPay[47:0]; // R12
      end else if (cipherReq && state_reg == `CMS_ST_OPER && !curAtLimit) begin
        cipherNonce <= cipherNonce + 48'h1;
      end
    end
  end

  // replies carry nonce, firmware version, key identifier and status; no key material is reachable here
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      replyValid <= 1'b0;
      replySubtype <= 8'h00;
      replyData <= 48'h0;
    end else begin
      replyValid <= 1'b0;
      if (replyAllowed && (hkNonce || hkFw || hkStat)) begin
        replyValid <= 1'b1; // R3
        replySubtype <= cmdSub[15:8];
        if (hkNonce) begin
          replyData <= cipherNonce; // R12
        end else if (hkFw) begin
          replyData <= {24'h0, FW_VERSION}; // R13
        end else begin
          replyData <= {38'h0, keyCheckFail, keyIdActive, statusCode}; // R14
        end
      end
    end
  end
endmodule

// *** sim/cms_properties.sv ***
`timescale 1ns/1ns
module cms_properties (
  input wire clk,
  input wire resetn,
  input wire katStart,
  input wire eraseReq,
  input wire [4:0] erasePage,
  input wire eraseAck,
  input wire keyLoadReady,
  input wire rdValid,
  input wire [4:0] rdByte,
  input wire cipherReq,
  input wire cipherGo,
  input wire [47:0] cipherNonce,
  input wire [5:0] keyIdActive,
  input wire dataOutEnable,
  input wire [2:0] statusCode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence last_ack;
    eraseReq && eraseAck && erasePage == 5'h1f;
  endsequence
  sequence chk_done;
    rdValid && rdByte == 5'h10;
  endsequence
  boot_test_a: assert property (!$past(resetn) |-> ##[0:1] katStart)
    else $error("self-test not started after reset");
  oper_pass_a: assert property (dataOutEnable |-> statusCode == 3'h5 && keyIdActive != 6'h0)
    else $error("operative without pass or key");
  error_quiet_a: assert property (statusCode == 3'h7 |-> !dataOutEnable && !cipherGo && !keyLoadReady)
    else $error("error state not inhibited");
  erase_quiet_a: assert property (eraseReq |-> !dataOutEnable && !keyLoadReady)
    else $error("outputs live during erase");
  page_step_a: assert property (eraseReq && eraseAck && erasePage != 5'h1f |=> erasePage == $past(erasePage) + 5'h1)
    else $error("erase page order broken");
  load_ready_a: assert property (last_ack |=> keyLoadReady && !eraseReq)
    else $error("key entry not reached after last page");
  load_cause_a: assert property ($rose(keyLoadReady) |-> $past(eraseAck) && $past(erasePage) == 5'h1f)
    else $error("key entry before erase finished");
  oper_cause_a: assert property ($rose(dataOutEnable) |-> $past(rdValid) && $past(rdByte) == 5'h10)
    else $error("operative without checksum read");
  go_step_a: assert property (cipherGo |-> $past(cipherReq) && cipherNonce == $past(cipherNonce) + 48'h1)
    else $error("grant without request or nonce step");
  key_read_c: cover property (chk_done);
endmodule
bind cms_state_control cms_properties u_props (.clk, .resetn, .katStart, .eraseReq, .erasePage, .eraseAck,
  .keyLoadReady, .rdValid, .rdByte, .cipherReq, .cipherGo, .cipherNonce, .keyIdActive, .dataOutEnable, .statusCode);

// *** sim/cms_partner.sv ***
`timescale 1ns/1ns
module cms_partner #(
  parameter [127:0] KNOWN_ANSWER_TEST = 128'h0
) (
  input wire clk,
  input wire katStart,
  input wire katBad,
  output reg katResultValid,
  output reg [127:0] katResult,
  input wire eraseReq,
  output reg eraseAck,
  input wire rdReq,
  input wire [4:0] rdPage,
  input wire [4:0] rdByte,
  input wire keyBad,
  output reg rdValid,
  output reg [7:0] rdCopyA,
  output reg [7:0] rdCopyB,
  output reg [7:0] rdCopyC
);
  reg [2:0] katDly;
  reg pend;
  wire [7:0] v;
  function [7:0] kb(input [4:0] p, input [4:0] b);
    kb = {3'h0, p} ^ {b, 3'h5};
  endfunction
  function [7:0] crc(input [4:0] p);
    integer j, k;
    begin
      crc = 8'h00;
      for (j = 0; j < 16; j = j + 1) begin
        crc = crc ^ kb(p, j[4:0]);
        for (k = 0; k < 8; k = k + 1)
          crc = crc[7] ? {crc[6:0], 1'b0} ^ 8'h07 : {crc[6:0], 1'b0};
      end
    end
  endfunction
  assign v = (rdByte == 5'h10) ? (crc(rdPage) ^ {7'h0, keyBad}) : kb(rdPage, rdByte);
  initial begin
    {katDly, pend, katResultValid, eraseAck, rdValid} = 0;
    {katResult, rdCopyA, rdCopyB, rdCopyC} = 0;
  end
  always @(posedge clk) begin
    katDly <= {katDly[1:0], katStart};
    katResultValid <= katDly[2];
    katResult <= katDly[2] ? (katBad ? ~KNOWN_ANSWER_TEST : KNOWN_ANSWER_TEST) : ~katResult;
    eraseAck <= eraseReq && !eraseAck;
    pend <= rdReq;
    rdValid <= pend;
    // one copy always corrupt so only a true vote recovers the byte
    rdCopyA <= pend ? v : ~rdCopyA;
    rdCopyB <= pend ? ~v : ~rdCopyB;
    rdCopyC <= pend ? v : ~rdCopyC;
  end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
`include "cms_defs.vh"
module tb_top;
  localparam [127:0] KNOWN_ANSWER_TEST = 128'h5a5a00ff1234abcd0f1e2d3c4b5a6978;
  localparam [23:0] FW = 24'h0a0b0c;
  logic clk, resetn, keyHarness, gndValid, gndEnd, hkValid, hkEnd, cipherReq, katBad, keyBad;
  logic [7:0] gndData, hkData;
  wire katStart, katResultValid, eraseReq, eraseAck, keyLoadReady, rdReq, rdValid, cipherGo;
  wire limitReached, keyCheckFail, dataOutEnable, replyValid;
  wire [127:0] katResult;
  wire [4:0] erasePage, rdPage, rdByte;
  wire [7:0] rdCopyA, rdCopyB, rdCopyC, replySubtype;
  wire [47:0] cipherNonce, replyData;
  wire [5:0] keyIdActive;
  wire [2:0] statusCode;
  integer miscompares = 0, num_checks = 0, seed = 72, gos = 0, pages = 0, k, m, r;
  logic [47:0] mNonce;
  logic [55:0] expQ[$];
  cms_state_control #(.KAT_EXPECTED(KNOWN_ANSWER_TEST), .FW_VERSION(FW)) u_dut (.clk, .resetn, .keyHarness, .katStart,
    .katResultValid, .katResult, .eraseReq, .erasePage, .eraseAck, .keyLoadReady, .rdReq, .rdPage, .rdByte,
    .rdValid, .rdCopyA, .rdCopyB, .rdCopyC, .gndValid, .gndData, .gndEnd, .hkValid, .hkData, .hkEnd,
    .cipherReq, .cipherGo, .cipherNonce, .keyIdActive, .limitReached, .keyCheckFail, .dataOutEnable,
    .statusCode, .replyValid, .replySubtype, .replyData);
  cms_partner #(.KNOWN_ANSWER_TEST(KNOWN_ANSWER_TEST)) u_far (.clk, .katStart, .katBad, .katResultValid, .katResult, .eraseReq,
    .eraseAck, .rdReq, .rdPage, .rdByte, .keyBad, .rdValid, .rdCopyA, .rdCopyB, .rdCopyC);
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task chk(input [55:0] got, input [55:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (cipherGo === 1'b1) gos <= gos + 1;
    if (eraseReq === 1'b1 && eraseAck === 1'b1) pages <= pages + 1;
    if (replyValid === 1'b1) begin
      if (expQ.size() == 0) chk(56'h1, 56'h0);
      else chk({replySubtype, replyData}, expQ.pop_front());
    end
  end
  task frame(input g, input [55:0] d, input integer n);
    integer j;
    for (j = 0; j < n; j = j + 1) begin
      @(posedge clk);
      gndValid <= g;
      hkValid <= !g;
      gndData <= d[55 - 8 * j -: 8];
      hkData <= d[55 - 8 * j -: 8];
      gndEnd <= g && j == n - 1;
      hkEnd <= !g && j == n - 1;
    end
    @(posedge clk);
    {gndValid, hkValid, gndEnd, hkEnd} <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
  task boot(input h, input b);
    keyHarness <= h;
    katBad <= b;
    resetn <= 0;
    pages = 0;
    repeat (16) @(posedge clk);
    resetn <= 1;
    repeat (12) @(posedge clk);
    #1 chk(statusCode, b ? 3'h7 : 3'h5);
  endtask
  task stop_test;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {resetn, keyHarness, gndValid, gndEnd, hkValid, hkEnd, cipherReq, katBad, keyBad} = 0;
    {gndData, hkData} = 0;
    boot(0, 1);
    frame(0, {`CMS_SUB_STAT_GET, 48'h0}, 1);
    @(posedge clk) cipherReq <= 1;
    @(posedge clk) cipherReq <= 0;
    repeat (3) @(posedge clk);
    chk({dataOutEnable, gos}, 0);
    boot(1, 0);
    frame(0, {`CMS_SUB_FW_GET, 48'h0}, 1);
    for (k = 0; k < 300 && keyLoadReady !== 1'b1; k++) @(posedge clk);
    chk({keyLoadReady, dataOutEnable, pages}, {2'b10, 32'd32});
    boot(0, 0);
    expQ.push_back({`CMS_SUB_FW_GET, 24'h0, FW});
    frame(0, {`CMS_SUB_FW_GET, 48'h0}, 1);
    // over-long, cut-short and mis-routed frames must leave no trace
    frame(0, {`CMS_SUB_FW_GET, 48'h0}, 2);
    frame(1, {`CMS_SUB_NONCE_SET, 48'h0}, 3);
    mNonce = {16'($random(seed)), 32'($random(seed))};
    frame(0, {`CMS_SUB_NONCE_SET, ~mNonce}, 7);
    chk(cipherNonce, 0);
    frame(1, {`CMS_SUB_NONCE_SET, mNonce}, 7);
    expQ.push_back({`CMS_SUB_NONCE_GET, mNonce});
    frame(0, {`CMS_SUB_NONCE_GET, 48'h0}, 1);
    expQ.push_back({`CMS_SUB_STAT_GET, 48'h5});
    frame(0, {`CMS_SUB_STAT_GET, 48'h0}, 1);
    keyBad <= 1;
    frame(0, {`CMS_SUB_KEY_SEL, 8'h03, 40'h0}, 2);
    for (k = 0; k < 300 && keyCheckFail !== 1'b1; k++) @(posedge clk);
    chk({keyCheckFail, dataOutEnable}, 2'b10);
    keyBad <= 0;
    frame(0, {`CMS_SUB_KEY_SEL, 8'h20, 40'h0}, 2);
    for (k = 0; k < 300 && dataOutEnable !== 1'b1; k++) @(posedge clk);
    chk({dataOutEnable, keyIdActive}, {1'b1, 6'h20});
    frame(0, {`CMS_SUB_KEY_SEL, 8'h21, 40'h0}, 2);
    chk({dataOutEnable, keyIdActive}, {1'b1, 6'h20});
    frame(0, {`CMS_SUB_KEY_SEL, 8'h00, 40'h0}, 2);
    chk({dataOutEnable, keyIdActive}, {1'b1, 6'h20});
    gos = 0;
    m = 0;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      r = $random(seed);
      cipherReq <= r[0];
      m = m + r[0];
    end
    @(posedge clk) cipherReq <= 0;
    repeat (3) @(posedge clk);
    chk(gos, m);
    chk(limitReached, 0);
    mNonce = mNonce + m;
    expQ.push_back({`CMS_SUB_NONCE_GET, mNonce});
    frame(0, {`CMS_SUB_NONCE_GET, 48'h0}, 1);
    chk(expQ.size(), 0);
    stop_test;
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    stop_test;
  end
endmodule
